//--- verilog/wd_params.svh
// Register offsets, field positions and reset values of the watchdog control block
`ifndef WD_PARAMS_SVH
`define WD_PARAMS_SVH

// Register byte offsets on the register port
`define WD_ADDR_W              12
`define WD_OFS_CTRL_INTERVAL   12'hECD
`define WD_OFS_CTRL_CLOCK_WIN  12'hECE
`define WD_OFS_PRESCALE_LOW    12'hECF
`define WD_OFS_PRESCALE_HIGH   12'hED0
`define WD_OFS_TIMER_STATUS    12'hED1

// Field positions
`define WD_SEN_BIT             0
`define WD_INTERVAL_LSB        1
`define WD_INTERVAL_MSB        5
`define WD_WINDOW_LSB          0
`define WD_WINDOW_MSB          2
`define WD_CLKSRC_LSB          4
`define WD_CLKSRC_MSB          6

// Field codes and reset values
`define WD_INTERVAL_CFG_OPEN   5'h1F
`define WD_INTERVAL_DEFAULT    5'h0B
`define WD_INTERVAL_LAST_LEGAL 5'h12
`define WD_INTERVAL_MIN        5'h00
`define WD_CLKSRC_CFG_OPEN     3'h7
`define WD_CLKSRC_DEFAULT      3'h0
`define WD_WINDOW_CFG_OPEN     3'h7
`define WD_WINDOW_FULL_OPEN    3'h7
`define WD_SEN_RESET           1'h0
`define WD_STATUS_RESET        8'h00

// Counter widths and limits
`define WD_PRESCALE_W          18
`define WD_TIMER_W             5
`define WD_TIMER_MAX           5'h1F
`define WD_WINDOW_STEP         5'h04
`define WD_WINDOW_STEPS        3'h7

`endif

//--- verilog/wd_pkg.sv
// Types shared by the watchdog control block and its counter core
package wd_pkg;

  // Configured operating modes
  typedef enum logic [1:0] {
    MODE_OFF   = 2'h0,
    MODE_SW    = 2'h1,
    MODE_AWAKE = 2'h2,
    MODE_ON    = 2'h3
  } op_mode_t;

  // Watchdog clock sources
  typedef enum logic [2:0] {
    SRC_LOW_FREQ = 3'h0,
    SRC_MID_FREQ = 3'h1
  } clk_src_t;

  typedef logic [17:0] prescale_t;
  typedef logic [4:0]  timer_t;

endpackage

//--- verilog/wd_core_if.sv
// Carrier between the watchdog register block and its counter core
`timescale 1ns/1ps
`default_nettype none

interface wd_core_if;
  logic               wd_tick;       // Selected watchdog clock enable
  logic               count_en;      // Watchdog active
  logic               clear;         // Zero both counters
  logic [4:0]         interval_code; // Effective interval code
  wd_pkg::prescale_t  prescale;
  wd_pkg::timer_t     timer;
  logic               overflow;      // One-cycle time-out pulse

  modport ctrl (output wd_tick, count_en, clear, interval_code,
                input prescale, timer, overflow);
  modport core (input wd_tick, count_en, clear, interval_code,
                output prescale, timer, overflow);
endinterface

`default_nettype wire

//--- verilog/wd_counter_core.sv
// Prescale counter and window timer of the watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wd_params.svh"

module wd_counter_core (
  input  wire logic SYS_CLK,
  input  wire logic SYS_RST,
  wd_core_if.core   cif
);

  logic [17:0] tap_mask;
  logic        tap;

  // Tap fires when the low interval bits of the prescaler are all ones
  always_comb begin
    tap_mask = 18'h00000;
    for (int i = 0; i < 18; i++) begin
      if (i < int'(cif.interval_code)) begin
        tap_mask[i] = 1'b1;
      end
    end
    tap = cif.wd_tick && ((cif.prescale & tap_mask) == tap_mask);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || cif.clear) begin
      cif.prescale <= 18'h00000;
    end else if (cif.count_en && cif.wd_tick) begin
      cif.prescale <= cif.prescale + 18'h00001;
    end
  end

  // tap advances timer, overflow times out
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || cif.clear) begin
      cif.timer    <= 5'h00;
      cif.overflow <= 1'b0;
    end else begin
      cif.overflow <= cif.count_en && tap && (cif.timer == `WD_TIMER_MAX);
      if (cif.count_en && tap) begin
        cif.timer <= cif.timer + 5'h01;
      end
    end
  end

endmodule

`default_nettype wire

//--- verilog/windowed_watchdog_control.sv
// Register set, enables and window checking of the windowed watchdog
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "wd_params.svh"

// Functional notes
// - Interval code sets division 32 up to 2^23
// - Reserved interval codes behave as minimum interval
// - Interval resets to config word or 01011
// - Interval writable only when config all ones
// - Software enable resets low, used in mode 01
// - Clock source 000 low, 001 mid oscillator
// - Clock source writable only with config 111
// - Window resets from config, writable at 111
// - Window code sets closed share in eighths
// - Window open at timer four times seven-minus-code
// - Status bit 2 shows armed flag
// - Status holds timer and top prescale bits
// - Prescaler readable as three byte views
// - Clear in closed window causes reset
// - Control writes clear the watchdog counters
// - Operating mode decides when watchdog runs
module windowed_watchdog_control (
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [11:0] REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [7:0]  REG_RDATA,
  input  wire logic [4:0]  CFG_INTERVAL_WORD,
  input  wire logic [2:0]  CFG_CLOCK_WORD,
  input  wire logic [2:0]  CFG_WINDOW_WORD,
  input  wire logic [1:0]  CFG_OPERATING_MODE,
  input  wire logic        DEVICE_SLEEP,
  input  wire logic        LOW_FREQ_TICK,
  input  wire logic        MID_FREQ_TICK,
  input  wire logic        CLEAR_INSTR,
  output var  logic        WD_RESET_REQ,
  output var  logic        WD_WINDOW_VIOLATION,
  output var  logic        WD_WAKE,
  output var  logic        WD_ACTIVE
);

  // ********************************************************
  // Declarations
  // ********************************************************

  wd_core_if cif ();

  logic [4:0]        interval_select;
  logic              software_enable_bit;
  logic [2:0]        clock_source_select;
  logic [2:0]        window_select;
  logic              armed;
  logic              active;
  logic              sleep_q;
  logic              sleep_edge;
  logic              wr_ctrl0;
  logic              wr_ctrl1;
  logic              rd_ctrl0;
  logic              windowed_mode;
  logic              window_open;
  logic [4:0]        open_threshold;
  logic              clear_valid;
  logic              clear_bad;
  logic              timeout;
  logic [4:0]        next_interval_code;
  logic              next_tick;
  logic [7:0]        next_rdata;
  wd_pkg::op_mode_t  op_mode;

  // ********************************************************
  // Register port decode
  // ********************************************************

  // Write strobes per control register, read strobe for control zero only
  assign wr_ctrl0 = REG_WR && (REG_ADDR == `WD_OFS_CTRL_INTERVAL);
  assign wr_ctrl1 = REG_WR && (REG_ADDR == `WD_OFS_CTRL_CLOCK_WIN);
  assign rd_ctrl0 = REG_RD && (REG_ADDR == `WD_OFS_CTRL_INTERVAL);

  // ********************************************************
  // Control registers
  // ********************************************************

  // interval locked unless config all ones
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      if (CFG_INTERVAL_WORD == `WD_INTERVAL_CFG_OPEN) begin
        interval_select <= `WD_INTERVAL_DEFAULT;
      end else begin
        interval_select <= CFG_INTERVAL_WORD;
      end
    end else if (wr_ctrl0 && (CFG_INTERVAL_WORD == `WD_INTERVAL_CFG_OPEN)) begin
      interval_select <= REG_WDATA[`WD_INTERVAL_MSB:`WD_INTERVAL_LSB];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      software_enable_bit <= `WD_SEN_RESET;
    end else if (wr_ctrl0) begin
      software_enable_bit <= REG_WDATA[`WD_SEN_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      if (CFG_CLOCK_WORD == `WD_CLKSRC_CFG_OPEN) begin
        clock_source_select <= `WD_CLKSRC_DEFAULT;
      end else begin
        clock_source_select <= CFG_CLOCK_WORD;
      end
    end else if (wr_ctrl1 && (CFG_CLOCK_WORD == `WD_CLKSRC_CFG_OPEN)) begin
      clock_source_select <= REG_WDATA[`WD_CLKSRC_MSB:`WD_CLKSRC_LSB];
    end
  end

  // window reset from config, locked unless config 111
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      window_select <= CFG_WINDOW_WORD;
    end else if (wr_ctrl1 && (CFG_WINDOW_WORD == `WD_WINDOW_CFG_OPEN)) begin
      window_select <= REG_WDATA[`WD_WINDOW_MSB:`WD_WINDOW_LSB];
    end
  end

  // ********************************************************
  // Operating mode and clock selection
  // ********************************************************

  assign op_mode = wd_pkg::op_mode_t'(CFG_OPERATING_MODE);

  // enable bit counts only in mode 01
  always_comb begin
    case (op_mode)
      wd_pkg::MODE_ON:    active = 1'b1;
      wd_pkg::MODE_AWAKE: active = !DEVICE_SLEEP;
      wd_pkg::MODE_SW:    active = software_enable_bit;
      default:            active = 1'b0;
    endcase
  end

  // source 000 low, 001 mid; reserved codes stop the clock
  always_comb begin
    case (clock_source_select)
      3'h0:    next_tick = LOW_FREQ_TICK;
      3'h1:    next_tick = MID_FREQ_TICK;
      default: next_tick = 1'b0;
    endcase
  end

  // code n divides by 32 times 2^n
  // reserved codes fall back to minimum
  always_comb begin
    if (interval_select > `WD_INTERVAL_LAST_LEGAL) begin
      next_interval_code = `WD_INTERVAL_MIN;
    end else begin
      next_interval_code = interval_select;
    end
  end

  // ********************************************************
  // Window checking and clearing
  // ********************************************************

  // code 111 leaves the window fully open
  assign windowed_mode = (window_select != `WD_WINDOW_FULL_OPEN);

  // open from four times seven minus code
  assign open_threshold = 5'((`WD_WINDOW_STEPS - window_select) * `WD_WINDOW_STEP);
  assign window_open    = (cif.timer >= open_threshold);

  // unarmed clear is a violation in windowed mode
  // clear in closed window is a violation
  assign clear_bad   = CLEAR_INSTR && active && windowed_mode && (!armed || !window_open);
  assign clear_valid = CLEAR_INSTR && !clear_bad;
  assign timeout     = cif.overflow;

  // Sleep entry and exit both restart the count
  assign sleep_edge = DEVICE_SLEEP ^ sleep_q;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= DEVICE_SLEEP;
    end
  end

  // reading control zero arms; arming beats a same-cycle clear
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      armed <= 1'b0;
    end else if (rd_ctrl0) begin
      armed <= 1'b1;
    end else if (CLEAR_INSTR || timeout || !active) begin
      armed <= 1'b0;
    end
  end

  // ********************************************************
  // Counter core
  // ********************************************************

  // control writes, valid clears and disable zero counters
  assign cif.clear = wr_ctrl0 || wr_ctrl1 || clear_valid || clear_bad
                   || !active || sleep_edge || timeout;
  assign cif.count_en      = active;
  assign cif.wd_tick       = next_tick;
  assign cif.interval_code = next_interval_code;

  wd_counter_core u_core (
    .SYS_CLK (SYS_CLK),
    .SYS_RST (SYS_RST),
    .cif     (cif)
  );

  // ********************************************************
  // Event outputs
  // ********************************************************

  // violation or time-out asks for reset; asleep, time-out wakes
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      WD_RESET_REQ        <= 1'b0;
      WD_WINDOW_VIOLATION <= 1'b0;
      WD_WAKE             <= 1'b0;
    end else begin
      WD_RESET_REQ        <= clear_bad || (timeout && !DEVICE_SLEEP);
      WD_WINDOW_VIOLATION <= clear_bad;
      WD_WAKE             <= timeout && DEVICE_SLEEP;
    end
  end

  // Activity shown one cycle late, straight from a flop
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      WD_ACTIVE <= 1'b0;
    end else begin
      WD_ACTIVE <= active;
    end
  end

  // ********************************************************
  // Read data
  // ********************************************************

  // armed flag at status bit 2
  // timer in 7:3, prescale top in 1:0
  always_comb begin
    case (REG_ADDR)
      `WD_OFS_CTRL_INTERVAL:  next_rdata = {2'h0, interval_select, software_enable_bit};
      `WD_OFS_CTRL_CLOCK_WIN: next_rdata = {1'h0, clock_source_select, 1'h0, window_select};
      `WD_OFS_PRESCALE_LOW:   next_rdata = cif.prescale[7:0];
      `WD_OFS_PRESCALE_HIGH:  next_rdata = cif.prescale[15:8];
      `WD_OFS_TIMER_STATUS:   next_rdata = {cif.timer, armed, cif.prescale[17:16]};
      default:                next_rdata = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= `WD_STATUS_RESET;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule

`default_nettype wire

//--- dv/wd_ctrl_asserts.sv
// Concurrent checks on the ports of the windowed watchdog control block
`timescale 1ns/1ps
`default_nettype none
`include "wd_params.svh"
module wd_ctrl_asserts (
  input wire logic        SYS_CLK,
  input wire logic        SYS_RST,
  input wire logic [11:0] REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [1:0]  CFG_OPERATING_MODE,
  input wire logic        LOW_FREQ_TICK,
  input wire logic        MID_FREQ_TICK,
  input wire logic        CLEAR_INSTR,
  input wire logic        WD_RESET_REQ,
  input wire logic        WD_WINDOW_VIOLATION,
  input wire logic        WD_ACTIVE
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // No watchdog tick, so the counters cannot move under a read
  logic quiet;
  assign quiet = !LOW_FREQ_TICK && !MID_FREQ_TICK;
  // Bus steps shared by the multi-step properties
  sequence s_rd_ctrl0; REG_RD && REG_ADDR == 12'hECD; endsequence
  sequence s_rd_status; REG_RD && REG_ADDR == 12'hED1 && !CLEAR_INSTR && quiet; endsequence
  sequence s_wr_ctrl; REG_WR && (REG_ADDR == 12'hECD || REG_ADDR == 12'hECE) && quiet; endsequence
  property p_rd_idle; !REG_RD |=> REG_RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_unmapped; REG_RD && (REG_ADDR < 12'hECD || REG_ADDR > 12'hED1) |=> REG_RDATA == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  // A write is followed by one idle edge before the next strobe
  property p_wr_clears;
    s_wr_ctrl ##1 (!REG_WR && !REG_RD && !CLEAR_INSTR && quiet) ##1 s_rd_status |=> REG_RDATA[7:3] == 5'h00;
  endproperty
  a_wr_clears: assert property (p_wr_clears) else $error("control write kept timer");
  property p_arm; s_rd_ctrl0 ##1 (!REG_WR && !CLEAR_INSTR) ##1 s_rd_status |=> REG_RDATA[2]; endproperty
  a_arm: assert property (p_arm) else $error("armed flag missing");
  property p_viol_cause; WD_WINDOW_VIOLATION |-> $past(CLEAR_INSTR); endproperty
  a_viol_cause: assert property (p_viol_cause) else $error("violation without clear");
  property p_viol_reset; WD_WINDOW_VIOLATION |-> WD_RESET_REQ; endproperty
  a_viol_reset: assert property (p_viol_reset) else $error("violation without reset");
  property p_off_quiet;
    CLEAR_INSTR && CFG_OPERATING_MODE == 2'h0 && $past(CFG_OPERATING_MODE) == 2'h0 |=> !WD_WINDOW_VIOLATION;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("violation while off");
  property p_mode_on; CFG_OPERATING_MODE == 2'h3 |=> WD_ACTIVE; endproperty
  a_mode_on: assert property (p_mode_on) else $error("not active in mode 11");
  property p_mode_off; CFG_OPERATING_MODE == 2'h0 |=> !WD_ACTIVE; endproperty
  a_mode_off: assert property (p_mode_off) else $error("active in mode 00");
endmodule
bind windowed_watchdog_control wd_ctrl_asserts chk_u (.SYS_CLK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_RD,
  .REG_RDATA, .CFG_OPERATING_MODE, .LOW_FREQ_TICK, .MID_FREQ_TICK, .CLEAR_INSTR, .WD_RESET_REQ,
  .WD_WINDOW_VIOLATION, .WD_ACTIVE);
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the windowed watchdog control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************************************
  // Stimulus and checking
  // ****************************************
  typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} reg_row_t;
  typedef struct packed {logic [7:0] c1; logic [7:0] c0; logic [7:0] n; logic lf; logic mf;
    logic [7:0] st; logic [7:0] ps;} run_row_t;
  logic        SYS_CLK = 1'h0;
  logic        SYS_RST = 1'h1;
  logic [11:0] REG_ADDR = 12'h000;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [7:0]  REG_RDATA;
  logic [4:0]  CFG_INTERVAL_WORD = 5'h1F;
  logic [2:0]  CFG_CLOCK_WORD = 3'h7;
  logic [2:0]  CFG_WINDOW_WORD = 3'h7;
  logic [1:0]  CFG_OPERATING_MODE = 2'h0;
  logic        REG_WR = 1'h0, REG_RD = 1'h0, DEVICE_SLEEP = 1'h0, CLEAR_INSTR = 1'h0;
  logic        LOW_FREQ_TICK = 1'h0, MID_FREQ_TICK = 1'h0;
  logic        WD_RESET_REQ, WD_WINDOW_VIOLATION, WD_WAKE, WD_ACTIVE;
  int          err_count = 0, tests_run = 0, cyc = 0;
  // Register rows: written with all fields open, read back
  reg_row_t regs [9] = '{'{12'hECF, 8'hFF, 8'h00}, '{12'hED0, 8'hFF, 8'h00}, '{12'hED1, 8'hFF, 8'h00},
    '{12'hECC, 8'h5A, 8'h00}, '{12'hED2, 8'h5A, 8'h00}, '{12'hECD, 8'hFF, 8'h3F},
    '{12'hECD, 8'h24, 8'h24}, '{12'hECE, 8'hFF, 8'h77}, '{12'hECE, 8'h12, 8'h12}};
  // Counting rows: source and interval, ticks, expected status and low count
  run_row_t runs [8] = '{'{8'h00, 8'h00, 8'h0A, 1'h1, 1'h0, 8'h50, 8'h0A},
    '{8'h00, 8'h00, 8'h00, 1'h0, 1'h0, 8'h00, 8'h00}, '{8'h00, 8'h02, 8'h0A, 1'h1, 1'h0, 8'h28, 8'h0A},
    '{8'h00, 8'h26, 8'h0A, 1'h1, 1'h0, 8'h50, 8'h0A}, '{8'h00, 8'h24, 8'h0A, 1'h1, 1'h0, 8'h00, 8'h0A},
    '{8'h10, 8'h00, 8'h0A, 1'h1, 1'h0, 8'h00, 8'h00}, '{8'h10, 8'h00, 8'h0A, 1'h0, 1'h1, 8'h50, 8'h0A},
    '{8'h20, 8'h00, 8'h0A, 1'h1, 1'h1, 8'h00, 8'h00}};

  windowed_watchdog_control dut_u (.SYS_CLK, .SYS_RST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .CFG_INTERVAL_WORD, .CFG_CLOCK_WORD, .CFG_WINDOW_WORD, .CFG_OPERATING_MODE,
    .DEVICE_SLEEP, .LOW_FREQ_TICK, .MID_FREQ_TICK, .CLEAR_INSTR, .WD_RESET_REQ, .WD_WINDOW_VIOLATION,
    .WD_WAKE, .WD_ACTIVE);

  // 200 MHz clock
  always #2.5 SYS_CLK = ~SYS_CLK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'h1;
    @(posedge SYS_CLK);
    REG_WR <= 1'h0;
    // Idle edge, so a following call never lowers and raises a strobe in one step
    @(posedge SYS_CLK);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    REG_ADDR <= a;
    REG_RD <= 1'h1;
    @(posedge SYS_CLK);
    REG_RD <= 1'h0;
    #1 chk(REG_RDATA, e);
    @(posedge SYS_CLK);
  endtask

  task automatic ticks(input int n, input logic lf, input logic mf);
    repeat (n) begin
      LOW_FREQ_TICK <= lf;
      MID_FREQ_TICK <= mf;
      @(posedge SYS_CLK);
    end
    LOW_FREQ_TICK <= 1'h0;
    MID_FREQ_TICK <= 1'h0;
  endtask

  task automatic clr(input logic v);
    CLEAR_INSTR <= 1'h1;
    @(posedge SYS_CLK);
    CLEAR_INSTR <= 1'h0;
    #1 chk(WD_WINDOW_VIOLATION, v);
    chk(WD_RESET_REQ, v);
    @(posedge SYS_CLK);
  endtask

  task automatic rst(input logic [4:0] iw, input logic [2:0] cw, input logic [2:0] ww);
    SYS_RST <= 1'h1;
    CFG_INTERVAL_WORD <= iw;
    CFG_CLOCK_WORD <= cw;
    CFG_WINDOW_WORD <= ww;
    repeat (3) @(posedge SYS_CLK);
    SYS_RST <= 1'h0;
    @(posedge SYS_CLK);
  endtask

  // Let the counters run out; asleep the time-out wakes instead of resetting
  task automatic tmo(input logic s);
    int   n;
    logic sr;
    logic sw;
    n = 0;
    sr = 1'h0;
    sw = 1'h0;
    DEVICE_SLEEP <= s;
    wr(12'hECD, 8'h00);
    LOW_FREQ_TICK <= 1'h1;
    while (!sr && !sw && n < 40) begin
      @(posedge SYS_CLK);
      #1 sr = WD_RESET_REQ;
      sw = WD_WAKE;
      n++;
    end
    // Inputs only change on a rising edge
    @(posedge SYS_CLK);
    LOW_FREQ_TICK <= 1'h0;
    DEVICE_SLEEP <= 1'h0;
    chk(sr, !s);
    chk(sw, s);
    chk(n >= 32 && n <= 34, 1'h1);
    @(posedge SYS_CLK);
  endtask

  task automatic act(input logic e);
    repeat (2) @(posedge SYS_CLK);
    #1 chk(WD_ACTIVE, e);
    @(posedge SYS_CLK);
  endtask

  initial begin
    rst(5'h1F, 3'h7, 3'h7);
    rd(12'hECD, 8'h16);
    rd(12'hECE, 8'h07);
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rd(regs[i].a, regs[i].e);
    end
    clr(1'h0);
    // Locked fields: only the enable bit takes a write
    rst(5'h05, 3'h1, 3'h3);
    rd(12'hECD, 8'h0A);
    rd(12'hECE, 8'h13);
    wr(12'hECD, 8'hFF);
    rd(12'hECD, 8'h0B);
    wr(12'hECE, 8'hFF);
    rd(12'hECE, 8'h13);
    rst(5'h1F, 3'h7, 3'h7);
    CFG_OPERATING_MODE <= 2'h3;
    foreach (runs[i]) begin
      wr(12'hECE, runs[i].c1);
      wr(12'hECD, runs[i].c0);
      ticks(runs[i].n, runs[i].lf, runs[i].mf);
      rd(12'hED1, runs[i].st);
      rd(12'hECF, runs[i].ps);
    end
    // Window code 000: open from timer 28
    wr(12'hECE, 8'h00);
    wr(12'hECD, 8'h00);
    ticks(28, 1'h1, 1'h0);
    clr(1'h1);
    wr(12'hECD, 8'h00);
    ticks(27, 1'h1, 1'h0);
    rd(12'hECD, 8'h00);
    rd(12'hED1, 8'hDC);
    clr(1'h1);
    wr(12'hECD, 8'h00);
    ticks(28, 1'h1, 1'h0);
    rd(12'hECD, 8'h00);
    clr(1'h0);
    rd(12'hED1, 8'h00);
    wr(12'hECE, 8'h07);
    clr(1'h0);
    tmo(1'h0);
    tmo(1'h1);
    CFG_OPERATING_MODE <= 2'h1;
    wr(12'hECD, 8'h00);
    act(1'h0);
    wr(12'hECD, 8'h01);
    act(1'h1);
    // Awake-only mode: asleep stops the watchdog, awake runs it
    CFG_OPERATING_MODE <= 2'h2;
    DEVICE_SLEEP <= 1'h1;
    act(1'h0);
    DEVICE_SLEEP <= 1'h0;
    act(1'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
